// ==== hdl/can_cmd_map.vh ====
// Purpose: constants for the engine CAN command decoder
// Assumes: frames arrive already received and checked by a CAN controller
// Notes:   bit numbers are zero-based inside byte 1 of each frame
`ifndef CAN_CMD_MAP_VH
`define CAN_CMD_MAP_VH

// parameter group numbers of the three command messages
`define PGN_ENGINE_CTRL   18'h0FF1C
`define PGN_STOP_CMD      18'h0FF1D
`define PGN_SPEED_REQ     18'h0FF1E

// engine control message, byte 1 fields
`define EC_RATED_A_BIT    0
`define EC_RATED_B_BIT    1
`define EC_DROOP_BIT      2
`define EC_RDROOP_BIT     3
`define EC_STARTER_BIT    4
`define EC_HIIDLE_EN_BIT  5
`define EC_HIIDLE_SP_BIT  6
`define EC_FIELD_MSB      6

// stop command codes, byte 1 bits 0..1
`define STOP_NONE         2'h0
`define STOP_REQ          2'h1
`define STOP_LSB          0
`define STOP_MSB          1

// speed request message: byte 1 low five bits, setpoint bytes 2..3
`define SPD_SEL_LSB       0
`define SPD_SEL_MSB       4
`define SPD_UP_ERR_HI     8'hFE
`define SEL_FIXED1_BIT    0
`define SEL_FIXED2_BIT    1
`define SEL_IMPL_UP_BIT   2
`define SEL_IMPL_DN_BIT   3
`define SEL_ENABLE_BIT    4

// reset values
`define RST_SEL           5'h00
`define RST_STARTER       1'h1
`define RST_SETPOINT      16'h0000
`define RST_EC            7'h00
`define RST_STOP          1'h0
`define RST_SETP_OK       1'h0

`endif

// ==== hdl/pin_sync3.v ====
// Purpose: three-stage synchroniser with agreement filter for one level
// Assumes: d may change at any time relative to core_clk
// Notes:   output changes once stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module pin_sync3
(
   // clock, reset, enable
   input  wire core_clk,
   input  wire srst,
   input  wire clk_en,
   // level in and filtered out
   input  wire d,
   output reg  q
);
   reg s1_q;
   reg s2_q;
   reg s3_q;

   // first stage feeds only the second
   always @(posedge core_clk)
   begin
      if (srst)
      begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         q    <= 1'b0;
      end
      else if (clk_en)
      begin
         s1_q <= d;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q)
            q <= s3_q;
      end
   end
endmodule // pin_sync3
`default_nettype wire

// ==== hdl/engine_can_command_decoder.v ====
// Purpose: decode the three command frames sent by the machine controller
// Assumes: a CAN controller on core_clk delivers each accepted frame as a
//          one-cycle strobe with its group number and eight data bytes
// Notes:   bus_error_pin comes from outside the clock domain and is
//          synchronised; application input settings gate each function except the stop command and the setpoint
//          a matching frame is stored on the edge that takes it and its
//          fields show at the outputs on the next clk_en edge
//          raw fields are stored even while their setting is low, so a
//          setting raised later shows the last commanded value at once
//          frames are still taken during a bus error; only starter
//          prevention reacts to the error level, the rest hold
//          the stop command is a level, kept until code 00 arrives;
//          codes 10 and 11 are dropped without any effect
//          a setpoint whose high byte is FE or FF is not stored and
//          setpoint_valid stays low until a usable one arrives
//          undefined bits and bytes of each frame are never looked at,
//          so a sender that leaves them at zero is still understood
//          limitation: the error level is filtered, so a pulse on the
//          error pin shorter than about two cycles may go unseen
//          clk_en low freezes every register, synchroniser included
//
// Contract
// - byte 1 bit 1: rated speed select a
// - byte 1 bit 2: rated speed select b
// - reset clears selections, modes, limits, speeds
// - bus error keeps last selections and modes
// - byte 1 bit 3: droop, else isochronous
// - byte 1 bit 4: reverse droop
// - byte 1 bit 5: starter prevention
// - after reset starter prevention is on
// - bus error forces starter prevention off
// - bits 6, 7: high idle enable, speed
// - stop code 01 stops; 10, 11 ignored
// - speed message bits 1-5 speed selection
// - selection bit 1: fixed speed one
// - selection bit 2: fixed speed two
// - bits 3, 4: implement up, down
// - selection bit 5: speed selection enable
`timescale 1ns/10ps
`default_nettype none
`include "can_cmd_map.vh"
module engine_can_command_decoder
#(
   parameter PGN_W = 18
)
(
   // clock, reset, enable
   input  wire              core_clk,
   input  wire              srst,
   input  wire              clk_en,
   // received frame from the CAN controller
   input  wire              frame_valid,
   input  wire [PGN_W-1:0]  frame_pgn,
   input  wire [63:0]       frame_data,
   // bus state, asynchronous pin level
   input  wire              bus_error_pin,
   // application input function settings
   input  wire              application_input_1,
   input  wire              application_input_2,
   input  wire              application_input_3,
   input  wire              application_input_4,
   input  wire              application_input_5,
   input  wire              application_input_6,
   input  wire              application_input_7,
   // decoded engine control
   output reg               rated_speed_select_a,
   output reg               rated_speed_select_b,
   output reg               droop_mode,
   output reg               reverse_droop_mode,
   output reg               starter_prevent,
   output reg               high_idle_limit,
   output reg               high_idle_speed,
   // decoded stop command
   output reg               engine_stop,
   // decoded speed request
   output reg               fixed_speed_1,
   output reg               fixed_speed_2,
   output reg               implement_up,
   output reg               implement_down,
   output reg               speed_select_enable,
   output reg  [15:0]       speed_up_setpoint,
   output reg               setpoint_valid,
   // status
   output wire              bus_error
);

   // engine control group, held until the next matching frame
   reg  [6:0]  ec_bits_q;
   reg  [6:0]  ec_bits_d;
   reg         starter_raw_q;
   reg         starter_raw_d;
   // stop command group
   reg         stop_q;
   reg         stop_d;
   // speed request group
   reg  [4:0]  sel_q;
   reg  [4:0]  sel_d;
   reg  [15:0] setp_q;
   reg  [15:0] setp_d;
   reg         setp_ok_q;
   reg         setp_ok_d;

   // byte lanes, filtered error level, group hits and frame fields
   wire [7:0]  byte1;
   wire [7:0]  byte2;
   wire [7:0]  byte3;
   wire        err_s;
   wire        hit_ec;
   wire        hit_stp;
   wire        hit_spd;
   wire [1:0]  stop_code;
   wire        setp_bad;

   // bus error level crosses in through the agreement filter
   pin_sync3 u_err_sync
   (
      .core_clk (core_clk),
      .srst     (srst),
      .clk_en   (clk_en),
      .d        (bus_error_pin),
      .q        (err_s)
   );

   assign bus_error = err_s;

   // byte 1 is the first byte on the wire, in the low lane
   assign byte1 = frame_data[7:0];
   assign byte2 = frame_data[15:8];
   assign byte3 = frame_data[23:16];

   // frames for other groups are left alone
   assign hit_ec  = frame_valid && (frame_pgn == `PGN_ENGINE_CTRL);
   assign hit_stp = frame_valid && (frame_pgn == `PGN_STOP_CMD);
   assign hit_spd = frame_valid && (frame_pgn == `PGN_SPEED_REQ);

   // stop code and setpoint error marker of the frame on the inputs
   assign stop_code = byte1[`STOP_MSB:`STOP_LSB];
   assign setp_bad  = (byte3 >= `SPD_UP_ERR_HI);         // FE or FF

   // next raw values; only defined bits are taken, the rest ignored
   always @*
   begin
      ec_bits_d     = ec_bits_q;
      starter_raw_d = starter_raw_q;
      stop_d        = stop_q;
      sel_d         = sel_q;
      setp_d        = setp_q;
      setp_ok_d     = setp_ok_q;
      // engine control frame
      if (hit_ec)
      begin
         ec_bits_d     = byte1[`EC_FIELD_MSB:0];
         starter_raw_d = byte1[`EC_STARTER_BIT];
      end
      // stop frame; codes 10 and 11 leave the stop state untouched
      if (hit_stp)
      begin
         if (stop_code == `STOP_REQ)
            stop_d = 1'b1;
         else if (stop_code == `STOP_NONE)
            stop_d = 1'b0;
      end
      // speed frame; a high byte of FE or FF keeps the old setpoint
      if (hit_spd)
      begin
         sel_d = byte1[`SPD_SEL_MSB:`SPD_SEL_LSB];
         if (!setp_bad)
         begin
            setp_d    = {byte3, byte2};
            setp_ok_d = 1'b1;
         end
         else
            setp_ok_d = 1'b0;
      end
   end

   // engine control raw fields; a bus error does not clear them, so
   // the last command returns as soon as the bus recovers
   always @(posedge core_clk)
   begin
      if (srst)
      begin
         ec_bits_q     <= `RST_EC;
         starter_raw_q <= `RST_STARTER;
      end
      else if (clk_en)
      begin
         ec_bits_q     <= ec_bits_d;
         starter_raw_q <= starter_raw_d;
      end
   end

   // stop command level, kept until the sender clears it with 00
   always @(posedge core_clk)
   begin
      if (srst)
         stop_q <= `RST_STOP;
      else if (clk_en)
         stop_q <= stop_d;
   end

   // speed request raw fields and setpoint, held through bus errors
   always @(posedge core_clk)
   begin
      if (srst)
      begin
         sel_q     <= `RST_SEL;
         setp_q    <= `RST_SETPOINT;
         setp_ok_q <= `RST_SETP_OK;
      end
      else if (clk_en)
      begin
         sel_q     <= sel_d;
         setp_q    <= setp_d;
         setp_ok_q <= setp_ok_d;
      end
   end

   // rated speed, governor and high idle outputs
   // a low setting forces its output off but the raw bit is kept
   always @(posedge core_clk)
   begin
      if (srst)
      begin
         rated_speed_select_a <= 1'b0;
         rated_speed_select_b <= 1'b0;
         droop_mode           <= 1'b0;
         reverse_droop_mode   <= 1'b0;
         high_idle_limit      <= 1'b0;
         high_idle_speed      <= 1'b0;
      end
      else if (clk_en)
      begin
         rated_speed_select_a <= application_input_7 &
                                 ec_bits_q[`EC_RATED_A_BIT];
         rated_speed_select_b <= application_input_2 &
                                 ec_bits_q[`EC_RATED_B_BIT];
         droop_mode           <= application_input_1 &
                                 ec_bits_q[`EC_DROOP_BIT];
         reverse_droop_mode   <= application_input_5 &
                                 ec_bits_q[`EC_RDROOP_BIT];
         high_idle_limit      <= application_input_5 &
                                 ec_bits_q[`EC_HIIDLE_EN_BIT];
         high_idle_speed      <= application_input_7 &
                                 ec_bits_q[`EC_HIIDLE_SP_BIT];
      end
   end

   // starter prevention: on out of reset, off while the bus is in error
   // the raw bit survives the error, so prevention returns afterwards
   always @(posedge core_clk)
   begin
      if (srst)
         starter_prevent <= `RST_STARTER;
      else if (clk_en)
      begin
         // bus error releases cranking rather than trusting old data
         starter_prevent <= ~err_s & application_input_1 &
                            starter_raw_q;
      end
   end

   // stop command output, a level rather than a pulse, so a missed
   // repeat frame cannot restart a stopped engine
   always @(posedge core_clk)
   begin
      if (srst)
         engine_stop <= `RST_STOP;
      else if (clk_en)
         engine_stop <= stop_q;
   end

   // speed selection outputs and setpoint
   // implement flags are gated like the others and driven out as ports
   always @(posedge core_clk)
   begin
      if (srst)
      begin
         fixed_speed_1       <= 1'b0;
         fixed_speed_2       <= 1'b0;
         implement_up        <= 1'b0;
         implement_down      <= 1'b0;
         speed_select_enable <= 1'b0;
         speed_up_setpoint   <= `RST_SETPOINT;
         setpoint_valid      <= `RST_SETP_OK;
      end
      else if (clk_en)
      begin
         fixed_speed_1       <= application_input_3 &
                                sel_q[`SEL_FIXED1_BIT];
         fixed_speed_2       <= application_input_4 &
                                sel_q[`SEL_FIXED2_BIT];
         implement_up        <= application_input_5 &
                                sel_q[`SEL_IMPL_UP_BIT];
         implement_down      <= application_input_6 &
                                sel_q[`SEL_IMPL_DN_BIT];
         speed_select_enable <= application_input_6 &
                                sel_q[`SEL_ENABLE_BIT];
         speed_up_setpoint   <= setp_q;
         setpoint_valid      <= setp_ok_q;
      end
   end

endmodule // engine_can_command_decoder
`default_nettype wire

// ==== verif/decoder_assertions.sv ====
// Purpose: port checks for the engine CAN command decoder
// Assumes: clk_en high, frames spaced four cycles or more
// Notes:   a taken frame is checked at the outputs three edges later
`timescale 1ns/10ps
`default_nettype none
`include "can_cmd_map.vh"
module decoder_assertions
(
   // every decoder port, several to a line to stay compact
   input wire logic        core_clk, srst, clk_en, frame_valid,
   input wire logic [17:0] frame_pgn,
   input wire logic [63:0] frame_data,
   input wire logic        bus_error_pin, bus_error, setpoint_valid,
   input wire logic        application_input_1, application_input_2,
   input wire logic        application_input_3, application_input_4,
   input wire logic        application_input_5, application_input_6,
   input wire logic        application_input_7,
   input wire logic        rated_speed_select_a, rated_speed_select_b,
   input wire logic        droop_mode, reverse_droop_mode, starter_prevent,
   input wire logic        high_idle_limit, high_idle_speed, engine_stop,
   input wire logic        fixed_speed_1, fixed_speed_2, implement_up,
   input wire logic        implement_down, speed_select_enable,
   input wire logic [15:0] speed_up_setpoint
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);
   // taken frames of each group
   wire ec = clk_en && frame_valid && frame_pgn == `PGN_ENGINE_CTRL;
   wire st = clk_en && frame_valid && frame_pgn == `PGN_STOP_CMD;
   wire sp = clk_en && frame_valid && frame_pgn == `PGN_SPEED_REQ;
   wire [4:0] sg = {application_input_6, application_input_6,
      application_input_5, application_input_4, application_input_3};
   wire [4:0] sel = {speed_select_enable, implement_down, implement_up,
      fixed_speed_2, fixed_speed_1};
   reset_state_a: assert property ($fell(srst) |-> starter_prevent
      && !rated_speed_select_a && !droop_mode && !high_idle_limit && sel == 0)
      else $error("bad state after reset");
   rated_a_a: assert property (ec |-> ##3 rated_speed_select_a ==
      ($past(frame_data[0], 3) & application_input_7)) else $error("rated a");
   rated_b_a: assert property (ec |-> ##3 rated_speed_select_b ==
      ($past(frame_data[1], 3) & application_input_2)) else $error("rated b");
   droop_bits_a: assert property (ec |-> ##3 {reverse_droop_mode,
      droop_mode} == ($past(frame_data[3:2], 3) & {application_input_5,
      application_input_1})) else $error("governor mode");
   starter_bit_a: assert property (ec && !bus_error |-> ##3
      starter_prevent == ($past(frame_data[4], 3) & application_input_1))
      else $error("starter prevention");
   error_starter_a: assert property (bus_error ##1 bus_error
      |-> !starter_prevent) else $error("starter kept in bus error");
   high_idle_a: assert property (ec |-> ##3 {high_idle_speed,
      high_idle_limit} == ($past(frame_data[6:5], 3) & {application_input_7,
      application_input_5})) else $error("high idle");
   stop_code_a: assert property (st |-> ##3 engine_stop ==
      ($past(frame_data[1], 3) ? $past(engine_stop, 3) :
      $past(frame_data[0], 3))) else $error("stop command");
   setpoint_refused_a: assert property (sp && frame_data[23:17] == 7'h7F
      |-> ##3 !setpoint_valid) else $error("setpoint refused");
   speed_sel_a: assert property (sp |-> ##3 sel ==
      ($past(frame_data[4:0], 3) & $past(sg, 3))) else $error("speed sel");
   setpoint_value_a: assert property (sp && frame_data[23:17] != 7'h7F
      |-> ##3
      setpoint_valid && speed_up_setpoint == $past(frame_data[23:8], 3))
      else $error("setpoint");
endmodule // decoder_assertions
bind engine_can_command_decoder decoder_assertions u_chk (.*);
`default_nettype wire

// ==== verif/machine_ctrl_model.sv ====
// Purpose: machine controller sending command frames
// Assumes: one frame at a time, four idle cycles after each
// Notes:   released frame lines show the inverse of the last frame
`timescale 1ns/10ps
`default_nettype none
module machine_ctrl_model
(
   // clock in, frame out
   input  wire logic        core_clk,
   output var  logic        frame_valid,
   output var  logic [17:0] frame_pgn,
   output var  logic [63:0] frame_data
);
   initial {frame_valid, frame_pgn, frame_data} = '0;
   // one-cycle strobe; undefined bytes sent as ones
   task send(input logic [17:0] p, input logic [23:0] b);
      @(posedge core_clk);
      frame_valid <= 1'b1;
      frame_pgn   <= p;
      frame_data  <= {40'hFFFFFFFFFF, b};
      @(posedge core_clk);
      frame_valid <= 1'b0;
      frame_pgn   <= ~p;
      frame_data  <= ~{40'hFFFFFFFFFF, b};
      repeat (4) @(posedge core_clk);
   endtask
endmodule // machine_ctrl_model
`default_nettype wire

// ==== verif/engine_can_command_decoder_test.sv ====
// Purpose: self-checking bench for the command decoder
// Assumes: clk_en tied high; partner model drives the frames
// Notes:   expected values are rebuilt from inputs, never from outputs
`timescale 1ns/10ps
`default_nettype none
`include "can_cmd_map.vh"
module engine_can_command_decoder_test;
   logic core_clk = 0, srst = 1, err_pin = 0, frame_valid;
   logic [7:1] ai = 7'h7F;
   logic [17:0] frame_pgn;
   logic [63:0] frame_data;
   logic [15:0] spd;
   logic ra, rb, dr, rd, sp, hl, hs, es, f1, f2, iu, id, se, sv, be;
   int n_mismatch = 0, cmp_count = 0, cyc = 0;
   always #20 core_clk = ~core_clk;
   machine_ctrl_model u_mc (.core_clk(core_clk), .frame_valid(frame_valid),
      .frame_pgn(frame_pgn), .frame_data(frame_data));
   engine_can_command_decoder u_dut (.core_clk(core_clk), .srst(srst),
      .clk_en(1'b1), .frame_valid(frame_valid), .frame_pgn(frame_pgn),
      .frame_data(frame_data), .bus_error_pin(err_pin),
      .application_input_1(ai[1]), .application_input_2(ai[2]),
      .application_input_3(ai[3]), .application_input_4(ai[4]),
      .application_input_5(ai[5]), .application_input_6(ai[6]),
      .application_input_7(ai[7]), .rated_speed_select_a(ra),
      .rated_speed_select_b(rb), .droop_mode(dr), .reverse_droop_mode(rd),
      .starter_prevent(sp), .high_idle_limit(hl), .high_idle_speed(hs),
      .engine_stop(es), .fixed_speed_1(f1), .fixed_speed_2(f2),
      .implement_up(iu), .implement_down(id), .speed_select_enable(se),
      .speed_up_setpoint(spd), .setpoint_valid(sv), .bus_error(be));
   task chk(input string n, input logic [23:0] e, input logic [23:0] g);
      cmp_count++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("mismatch %s exp %h got %h", n, e, g);
      end
   endtask
   task print_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // hang guard: whole run is about a hundred cycles
   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         n_mismatch++;
         print_verdict;
      end
   end
   task t_ctrl;
      logic [7:0] d [3] = '{8'h7F, 8'hAA, 8'hFF};
      logic [7:1] g [3] = '{7'h7F, 7'h7F, 7'h00};
      chk("reset", 16'h0001, {hl, dr, ra, f1, es, spd, sp});
      for (int i = 0; i < 3; i++)
      begin
         ai <= g[i];
         u_mc.send(`PGN_ENGINE_CTRL, {16'hFFFF, d[i]});
         chk("ctrl", {g[i][7], g[i][5], g[i][1], g[i][5], g[i][1], g[i][2],
            g[i][7]} & d[i][6:0], {hs, hl, sp, rd, dr, rb, ra});
      end
      ai <= 7'h7F;
      $display("done ctrl");
   endtask
   task t_stop;
      logic [1:0] c [5] = '{2'h1, 2'h2, 2'h3, 2'h0, 2'h2};
      logic e [5] = '{1, 1, 1, 0, 0};
      for (int i = 0; i < 5; i++)
      begin
         u_mc.send(`PGN_STOP_CMD, {16'hFFFF, 6'h3F, c[i]});
         chk("stop", e[i], es);
      end
      $display("done stop");
   endtask
   task t_speed;
      u_mc.send(`PGN_SPEED_REQ, 24'h1234FF);
      chk("sel", 5'h1F, {se, id, iu, f2, f1});
      chk("setpoint", 17'h02469, {spd, sv});
      ai <= 7'h27;
      u_mc.send(`PGN_SPEED_REQ, 24'hFE00F5);
      chk("gated", 5'h11, {se, id, iu, f2, f1});
      chk("fe byte", 17'h02468, {spd, sv});
      u_mc.send(18'h0FF1B, 24'h0000E0);
      chk("other pgn", 5'h11, {se, id, iu, f2, f1});
      ai <= 7'h7F;
      $display("done speed");
   endtask
   task t_err;
      u_mc.send(`PGN_ENGINE_CTRL, 24'hFFFF13);
      err_pin <= 1'b1;
      repeat (8) @(posedge core_clk);
      chk("error", 2'h2, {be, sp});
      chk("kept", 3'h3, {dr, rb, ra});
      err_pin <= 1'b0;
      repeat (8) @(posedge core_clk);
      chk("error off", 2'h1, {be, sp});
      $display("done error");
   endtask
   // mid-run reset after frames have set several outputs
   task t_reset;
      srst <= 1'b1;
      repeat (3) @(posedge core_clk);
      srst <= 1'b0;
      repeat (2) @(posedge core_clk);
      chk("mid reset", 16'h0001, {hl, dr, ra, f1, es, spd, sp});
      chk("mid reset rest", 8'h00, {rb, rd, hs, f2, iu, id, se, sv});
      $display("done reset");
   endtask
   initial
   begin
      repeat (10) @(posedge core_clk);
      srst <= 1'b0;
      repeat (2) @(posedge core_clk);
      t_ctrl;
      t_stop;
      t_speed;
      t_err;
      t_reset;
      print_verdict;
   end
endmodule // engine_can_command_decoder_test
`default_nettype wire
